// ==== inc/uem_pkg.sv ====
// Package for the USB error interrupt masking block: map, fields, types.
package uem_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [11:0] ENABLE_OFFSET = 12'h000;
  localparam logic [11:0] FLAG_OFFSET = 12'h004;
  localparam logic [11:0] ROUTE_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00c;

  // ==========================================================================
  // Field positions of the enable and flag registers
  // ==========================================================================
  localparam int STUFF_BIT = 7;
  localparam int TIMEOUT_BIT = 4;
  localparam int PARTIAL_BIT = 3;
  localparam int DATA_CRC_BIT = 2;
  localparam int TOKEN_CRC_BIT = 1;
  localparam int PID_BIT = 0;
  localparam logic [7:0] IMPL_MASK = 8'h9f;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ==========================================================================
  // Descriptor routing
  // ==========================================================================
  localparam logic [15:0] PORT_ROUTE_POINTER = 16'hffff;
  localparam int KEEP_OWN_BIT = 5;
  localparam int STEP_DIS_BIT = 4;
  localparam logic [7:0] DESC_STATUS_RESET = 8'h00;
  localparam logic [15:0] DESC_POINTER_RESET = 16'h0000;

  // ==========================================================================
  // Turnaround timing: 16 bit times at 12 Mbit/s, counted on pclk
  // ==========================================================================
  localparam int IDLE_BIT_LIMIT = 16;
  localparam int BIT_TIME_PS = 83333;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TURNAROUND_CYCLES =
    (IDLE_BIT_LIMIT * BIT_TIME_PS) / CLK_PERIOD_PS;
  localparam logic [7:0] TURNAROUND_COUNT = 8'(TURNAROUND_CYCLES);
  localparam logic [7:0] COUNT_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] flags;
    logic [15:0] desc_pointer;
    logic [7:0] desc_status;
    logic [7:0] idle_count;
    logic waiting;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [31:0] prdata;
  } uem_state_t;

  typedef struct packed {
    logic port_route;
    logic keep_ownership;
    logic step_disable;
  } uem_route_t;

endpackage

// ==== hdl/uem_route_decode.sv ====
// Descriptor decoder that recognises the parallel port route.
`timescale 1ns/1ps

module uem_route_decode (
  input wire logic [15:0] descriptor_buffer_pointer,
  input wire logic [7:0] descriptor_status_byte,
  output uem_pkg::uem_route_t route
);

  // ==========================================================================
  // Decode
  // ==========================================================================
  always_comb begin
    route.port_route =
      (descriptor_buffer_pointer == uem_pkg::PORT_ROUTE_POINTER);
    route.keep_ownership =
      descriptor_status_byte[uem_pkg::KEEP_OWN_BIT];
    route.step_disable =
      descriptor_status_byte[uem_pkg::STEP_DIS_BIT];
  end

endmodule

// ==== hdl/uem_error_mask.sv ====
// Error flag capture and masking onto one top-level error interrupt flag.
// Behaviour
// - A set enable bit lets its error flag reach the top error flag.
// - Enables gate forwarding only; flags still set and stay pollable.
// - Bit stuffing enable sits at bit 7 of the enable register.
// - Enable bits 6 and 5 are unimplemented and read zero.
// - Turnaround time-out enable sits at bit 4.
// - Partial byte data field enable sits at bit 3.
// - Data 16-bit checksum enable sits at bit 2.
// - Token 5-bit checksum enable sits at bit 1.
// - Packet identifier check enable sits at bit 0.
// - An endpoint can route data through the parallel port.
// - Keep-ownership bit 5 keeps the buffer with the engine.
// - Step-disable bit 4 holds the buffer address fixed.
// - Top flag is the OR of flags each gated by its enable.
// - Flags set on detection and stay until firmware writes zero.
// - Time-out flag sets after more than 16 idle bit times.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module uem_error_mask (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stuff_error,
  input wire logic partial_byte_error,
  input wire logic data_checksum_error,
  input wire logic token_checksum_error,
  input wire logic packet_id_error,
  input wire logic end_of_packet,
  input wire logic response_seen,
  input wire logic line_idle,
  output logic top_error_interrupt_flag,
  output logic [7:0] usb_error_flag_register,
  output logic streaming_parallel_port_route,
  output logic keep_buffer_ownership,
  output logic address_step_disable
);

  // ==========================================================================
  // State
  // ==========================================================================
  uem_pkg::uem_state_t state_reg;
  uem_pkg::uem_state_t state_next;
  uem_pkg::uem_route_t route;
  logic [7:0] detect;
  logic [7:0] usb_error_irq_enable;
  logic wr;
  logic rd;
  logic mapped;
  logic eop_s;
  logic resp_s;
  logic idle_s;

  assign usb_error_irq_enable = state_reg.enable;

  uem_route_decode u_route (
    .descriptor_buffer_pointer(state_reg.desc_pointer),
    .descriptor_status_byte(state_reg.desc_status),
    .route(route)
  );

  // ==========================================================================
  // Bus decode
  // ==========================================================================
  // The slave answers in the first access cycle, so pready is always high.
  assign pready = 1'b1;
  assign mapped = (paddr == uem_pkg::ENABLE_OFFSET) ||
                  (paddr == uem_pkg::FLAG_OFFSET) ||
                  (paddr == uem_pkg::ROUTE_OFFSET) ||
                  (paddr == uem_pkg::STATUS_OFFSET);
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && mapped;
  assign rd = psel && !penable && !pwrite;

  // Pin inputs are filtered: end_of_packet and response_seen count as high once stages two and three agree.
  // Line activity counts only when both stages read low, so a single
  // disagreeing stage cannot end the wait early.
  assign eop_s = state_reg.sync_a[1] & state_reg.sync_a[2];
  assign resp_s = state_reg.sync_b[1] & state_reg.sync_b[2];
  assign idle_s = state_reg.sync_c[1] | state_reg.sync_c[2];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    state_next.sync_a = {state_reg.sync_a[1:0], end_of_packet};
    state_next.sync_b = {state_reg.sync_b[1:0], response_seen};
    state_next.sync_c = {state_reg.sync_c[1:0], line_idle};

    detect = 8'h00;
    detect[uem_pkg::STUFF_BIT] = stuff_error;
    detect[uem_pkg::PARTIAL_BIT] = partial_byte_error;
    detect[uem_pkg::DATA_CRC_BIT] = data_checksum_error;
    detect[uem_pkg::TOKEN_CRC_BIT] = token_checksum_error;
    detect[uem_pkg::PID_BIT] = packet_id_error;

    // Idle watch: a response or line activity ends the wait.
    if (eop_s) begin
      state_next.waiting = 1'b1;
      state_next.idle_count = uem_pkg::COUNT_RESET;
    end else if (resp_s || !idle_s) begin
      state_next.waiting = 1'b0;
      state_next.idle_count = uem_pkg::COUNT_RESET;
    end else if (state_reg.waiting) begin
      if (state_reg.idle_count == uem_pkg::TURNAROUND_COUNT) begin
        detect[uem_pkg::TIMEOUT_BIT] = 1'b1;
        state_next.waiting = 1'b0;
      end else begin
        state_next.idle_count = state_reg.idle_count + 8'h01;
      end
    end

    // Writing zero clears a flag; a same-cycle detection wins.
    if (wr && paddr == uem_pkg::FLAG_OFFSET) begin
      state_next.flags = state_reg.flags & pwdata[7:0];
    end
    state_next.flags = (state_next.flags | detect) &
                       uem_pkg::IMPL_MASK;

    if (wr && paddr == uem_pkg::ENABLE_OFFSET) begin
      state_next.enable = pwdata[7:0] & uem_pkg::IMPL_MASK;
    end
    if (wr && paddr == uem_pkg::ROUTE_OFFSET) begin
      state_next.desc_pointer = pwdata[15:0];
      state_next.desc_status = pwdata[23:16];
    end

    if (rd) begin
      unique case (paddr)
        uem_pkg::ENABLE_OFFSET:
          state_next.prdata = {24'h000000, state_reg.enable};
        uem_pkg::FLAG_OFFSET:
          state_next.prdata = {24'h000000, state_reg.flags};
        uem_pkg::ROUTE_OFFSET:
          state_next.prdata = {8'h00, state_reg.desc_status,
                               state_reg.desc_pointer};
        uem_pkg::STATUS_OFFSET:
          state_next.prdata = {28'h0000000, route.step_disable,
                               route.keep_ownership, route.port_route,
                               top_error_interrupt_flag};
        default:
          state_next.prdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.enable <= uem_pkg::ENABLE_RESET;
      state_reg.flags <= uem_pkg::FLAG_RESET;
      state_reg.desc_pointer <= uem_pkg::DESC_POINTER_RESET;
      state_reg.desc_status <= uem_pkg::DESC_STATUS_RESET;
      state_reg.idle_count <= uem_pkg::COUNT_RESET;
      state_reg.waiting <= 1'b0;
      state_reg.sync_a <= 3'h0;
      state_reg.sync_b <= 3'h0;
      state_reg.sync_c <= 3'h0;
      state_reg.prdata <= 32'h00000000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign top_error_interrupt_flag =
    |(state_reg.flags & usb_error_irq_enable);
  assign usb_error_flag_register = state_reg.flags;
  assign prdata = state_reg.prdata;
  assign streaming_parallel_port_route = route.port_route;
  assign keep_buffer_ownership =
    route.port_route & route.keep_ownership;
  assign address_step_disable =
    route.port_route & route.step_disable;

endmodule

// ==== verification/uem_error_mask_properties.sv ====
// Concurrent checks on the ports of the error mask block.
`timescale 1ns/1ps
module uem_error_mask_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic stuff_error,
  input wire logic partial_byte_error,
  input wire logic packet_id_error,
  input wire logic top_error_interrupt_flag,
  input wire logic [7:0] usb_error_flag_register,
  input wire logic streaming_parallel_port_route,
  input wire logic keep_buffer_ownership,
  input wire logic address_step_disable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] fl;
  logic clr;
  assign fl = usb_error_flag_register;
  assign clr = psel && penable && pwrite && paddr == uem_pkg::FLAG_OFFSET &&
               !pwdata[0];
  chk_stuff_set:
    assert property (stuff_error |=> fl[7]) else $error("stuff flag");
  chk_partial_set:
    assert property (partial_byte_error |=> fl[3]) else $error("partial");
  chk_flag_hold:
    assert property (fl[0] && !clr |=> fl[0]) else $error("flag lost");
  chk_flag_clear:
    assert property (clr && !packet_id_error |=> !fl[0])
    else $error("flag not cleared");
  chk_gap_read:
    assert property (psel && !penable && !pwrite && paddr == 12'h000
      |=> prdata[6:5] == 2'b00) else $error("gap bits read one");
  chk_top_source:
    assert property (top_error_interrupt_flag |-> fl != 8'h00)
    else $error("top flag without source");
  chk_reset_quiet:
    assert property ($rose(presetn) |-> !top_error_interrupt_flag)
    else $error("top flag after reset");
  chk_keep_route:
    assert property (keep_buffer_ownership |-> streaming_parallel_port_route)
    else $error("keep without route");
  chk_step_route:
    assert property (address_step_disable |-> streaming_parallel_port_route)
    else $error("step disable without route");
endmodule

bind uem_error_mask uem_error_mask_properties u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .stuff_error,
  .partial_byte_error, .packet_id_error, .top_error_interrupt_flag,
  .usb_error_flag_register, .streaming_parallel_port_route,
  .keep_buffer_ownership, .address_step_disable);

// ==== verification/uem_engine_model.sv ====
// Engine-side model that raises error pulses and packet timing pins.
`timescale 1ns/1ps
module uem_engine_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic [2:0] kind,
  output logic [7:0] err,
  output logic end_of_packet,
  output logic response_seen,
  output logic line_idle
);
  logic [2:0] eop_cnt = 3'h0;
  assign err = (go && kind != 3'h4) ? (8'h01 << kind) : 8'h00;
  // End of packet lasts four cycles so the pin synchroniser sees it.
  always_ff @(posedge pclk) begin
    eop_cnt <= (go && kind == 3'h4) ? 3'h4 : eop_cnt - (eop_cnt != 3'h0);
  end
  assign end_of_packet = eop_cnt != 3'h0;
  // Pulses are one pclk wide; the bench clock stands in for the engine
  // clock, whose full-speed rate is a system matter outside this block.
  // A silent bus: idle and no answer ever comes back.
  assign line_idle = 1'b1;
  assign response_seen = 1'b0;
endmodule

// ==== verification/uem_error_mask_tb.sv ====
// Self-checking bench for the error mask block.
`timescale 1ns/1ps
module uem_error_mask_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic go = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, slv, top, rt, keep, step, eop, resp, idle;
  logic [7:0] fl, err;
  int failures = 0;
  int comparisons = 0;
  initial forever #5 pclk = ~pclk;
  uem_engine_model u_uem_engine_model (.pclk, .go, .kind, .err,
    .end_of_packet(eop), .response_seen(resp), .line_idle(idle));
  uem_error_mask u_uem_error_mask (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stuff_error(err[7]), .partial_byte_error(err[3]),
    .data_checksum_error(err[2]), .token_checksum_error(err[1]),
    .packet_id_error(err[0]), .end_of_packet(eop), .response_seen(resp),
    .line_idle(idle), .top_error_interrupt_flag(top),
    .usb_error_flag_register(fl), .streaming_parallel_port_route(rt),
    .keep_buffer_ownership(keep), .address_step_disable(step));
  task automatic results();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input int d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      results();
    end
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic fire(input logic [2:0] k);
    @(posedge pclk);
    kind <= k;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(1'b0, uem_pkg::ENABLE_OFFSET, 0);
    chk("enable reset", q, 32'h0);
    apb(1'b1, uem_pkg::ENABLE_OFFSET, -1);
    apb(1'b0, uem_pkg::ENABLE_OFFSET, 0);
    chk("enable bits", q, 32'h9f);
    apb(1'b0, 12'h010, 0);
    chk("unmapped data", q, 32'h0);
    chk("unmapped error", {31'h0, slv}, 32'h1);
  endtask
  task automatic t_mask();
    logic [2:0] b [6] = '{3'h7, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
    logic [7:0] m;
    int i, n;
    for (i = 0; i < 6; i++) begin
      m = 8'h01 << b[i];
      apb(1'b1, uem_pkg::ENABLE_OFFSET, {24'h0, 8'h9f ^ m});
      fire(b[i]);
      if (b[i] == 3'h4) begin
        repeat (110) @(posedge pclk);
        chk("early timeout", {24'h0, fl}, 32'h0);
        n = 0;
        while (fl[4] !== 1'b1 && n < 200) begin
          @(posedge pclk);
          n++;
        end
      end
      apb(1'b0, uem_pkg::FLAG_OFFSET, 0);
      chk("flag set", q, {24'h0, m});
      chk("masked top", {31'h0, top}, 32'h0);
      apb(1'b1, uem_pkg::ENABLE_OFFSET, {24'h0, m});
      chk("enabled top", {31'h0, top}, 32'h1);
      apb(1'b1, uem_pkg::FLAG_OFFSET, 0);
      chk("cleared", {23'h0, top, fl}, 32'h0);
    end
  endtask
  task automatic t_route();
    apb(1'b1, uem_pkg::ROUTE_OFFSET, 32'h0030ffff);
    chk("route", {29'h0, rt, keep, step}, 32'h7);
    apb(1'b0, uem_pkg::STATUS_OFFSET, 0);
    chk("status", q & 32'he, 32'he);
    apb(1'b1, uem_pkg::ROUTE_OFFSET, 32'h0030fffe);
    chk("no route", {29'h0, rt, keep, step}, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mask();
    t_route();
    results();
  end
endmodule
